// ---- milt_pkg.sv ----
// Shared constants and types for the instruction length and timing sequencer
package milt_pkg;
  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int OPC_W = 8;
  localparam int PC_W  = 16;
  localparam int LEN_W = 2;
  localparam int CYC_W = 4;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [PC_W-1:0]  PC_RESET  = 16'h0000;
  localparam logic [OPC_W-1:0] OPC_RESET = 8'h00;

  // ---------------------------------------------------------------------------
  // Instruction byte lengths and execution cycle counts
  // ---------------------------------------------------------------------------
  localparam logic [LEN_W-1:0] LEN_ONE   = 2'h1;
  localparam logic [LEN_W-1:0] LEN_TWO   = 2'h2;
  localparam logic [LEN_W-1:0] LEN_THREE = 2'h3;
  localparam logic [CYC_W-1:0] CYC_ONE   = 4'h1;
  localparam logic [CYC_W-1:0] CYC_TWO   = 4'h2;
  localparam logic [CYC_W-1:0] CYC_THREE = 4'h3;
  localparam logic [CYC_W-1:0] CYC_TEN   = 4'ha;

  // ---------------------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    S_FETCH_OP,
    S_FETCH_ARG,
    S_EXEC
  } milt_state_e;
endpackage

// ---- milt_opcode_table.sv ----
// Opcode to byte length and cycle count lookup
`timescale 1ns/1ps
module milt_opcode_table (
  input  wire logic [milt_pkg::OPC_W-1:0] opcode,
  output logic      [milt_pkg::LEN_W-1:0] len,
  output logic      [milt_pkg::CYC_W-1:0] cyc
);
  // ---------------------------------------------------------------------------
  // Lookup
  // ---------------------------------------------------------------------------
  // Unlisted codes fall to one byte, one cycle so the fetch never stalls
  always_comb begin
    len = milt_pkg::LEN_ONE;
    cyc = milt_pkg::CYC_ONE;
    casez (opcode)
      8'h25, 8'h24, 8'h35, 8'h34: begin
        len = milt_pkg::LEN_TWO;
        cyc = milt_pkg::CYC_ONE;
      end
      8'h95, 8'h94: begin
        len = milt_pkg::LEN_TWO;
        cyc = milt_pkg::CYC_ONE;
      end
      8'h54, 8'h44, 8'h64, 8'he5, 8'hc2, 8'hd2, 8'hb2, 8'h72, 8'ha2: begin
        len = milt_pkg::LEN_TWO;
        cyc = milt_pkg::CYC_ONE;
      end
      8'ha0, 8'h92: begin
        len = milt_pkg::LEN_TWO;
        cyc = milt_pkg::CYC_ONE;
      end
      8'h55, 8'h52, 8'h45, 8'h42, 8'h65, 8'h62, 8'h05, 8'h15: begin
        len = milt_pkg::LEN_TWO;
        cyc = milt_pkg::CYC_TWO;
      end
      8'b1010_1???, 8'b0111_1???, 8'hf5, 8'b1000_1???, 8'h86, 8'h87, 8'h76, 8'h77,
      8'hc5, 8'h82: begin
        len = milt_pkg::LEN_TWO;
        cyc = milt_pkg::CYC_TWO;
      end
      8'hc0, 8'hd0: begin
        len = milt_pkg::LEN_TWO;
        cyc = milt_pkg::CYC_TWO;
      end
      8'hb0: begin
        len = milt_pkg::LEN_TWO;
        cyc = milt_pkg::CYC_TWO;
      end
      8'h40, 8'h50, 8'h80, 8'h60, 8'h70, 8'b1101_1???: begin
        len = milt_pkg::LEN_TWO;
        cyc = milt_pkg::CYC_TWO;
      end
      8'h74, 8'ha6, 8'ha7, 8'h?1: begin
        len = milt_pkg::LEN_TWO;
        cyc = milt_pkg::CYC_THREE;
      end
      8'h53, 8'h43, 8'h63, 8'h75, 8'h20, 8'hd5: begin
        len = milt_pkg::LEN_THREE;
        cyc = milt_pkg::CYC_TWO;
      end
      8'h85, 8'h90, 8'h30, 8'h10, 8'h12, 8'h02: begin
        len = milt_pkg::LEN_THREE;
        cyc = milt_pkg::CYC_THREE;
      end
      8'b1011_01??, 8'b1011_1???: begin
        len = milt_pkg::LEN_THREE;
        cyc = milt_pkg::CYC_THREE;
      end
      8'hf6, 8'hf7, 8'hf2, 8'hf3, 8'h93, 8'h73: begin
        len = milt_pkg::LEN_ONE;
        cyc = milt_pkg::CYC_TWO;
      end
      8'b1100_1???, 8'hc6, 8'hc7, 8'hd6, 8'hd7: begin
        len = milt_pkg::LEN_ONE;
        cyc = milt_pkg::CYC_TWO;
      end
      8'b1111_1???, 8'ha3, 8'ha4, 8'h22, 8'h32: begin
        len = milt_pkg::LEN_ONE;
        cyc = milt_pkg::CYC_THREE;
      end
      8'h84: begin
        len = milt_pkg::LEN_ONE;
        cyc = milt_pkg::CYC_TEN;
      end
      default: begin
        len = milt_pkg::LEN_ONE;
        cyc = milt_pkg::CYC_ONE;
      end
    endcase
  end
endmodule // milt_opcode_table

// ---- milt_sequencer.sv ----
// Fetch and timing sequencer of the embedded 8-bit core
`timescale 1ns/1ps
module milt_sequencer (
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic [milt_pkg::OPC_W-1:0] code_rdata,
  input  wire logic                       code_rvalid,
  input  wire logic                       branch_req,
  input  wire logic [milt_pkg::PC_W-1:0]  branch_target,
  output logic      [milt_pkg::PC_W-1:0]  code_addr,
  output logic                            code_rd,
  output logic      [milt_pkg::OPC_W-1:0] instr_opcode,
  output logic      [milt_pkg::OPC_W-1:0] instr_arg1,
  output logic      [milt_pkg::OPC_W-1:0] instr_arg2,
  output logic                            instr_start,
  output logic                            instr_done,
  output logic                            exec_active,
  output logic      [milt_pkg::PC_W-1:0]  prog_counter
);
  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  milt_pkg::milt_state_e          st_r,    st_nxt;
  logic [milt_pkg::PC_W-1:0]      pc_r,    pc_nxt;
  logic [milt_pkg::PC_W-1:0]      ipc_r,   ipc_nxt;
  logic [milt_pkg::PC_W-1:0]      addr_r,  addr_nxt;
  logic [milt_pkg::PC_W-1:0]      tgt_r,   tgt_nxt;
  logic                           rd_r,    rd_nxt;
  logic                           pend_r,  pend_nxt;
  logic                           br_r,    br_nxt;
  logic                           start_r, start_nxt;
  logic                           done_r,  done_nxt;
  logic                           exec_r,  exec_nxt;
  logic [milt_pkg::OPC_W-1:0]     opc_r,   opc_nxt;
  logic [milt_pkg::OPC_W-1:0]     a1_r,    a1_nxt;
  logic [milt_pkg::OPC_W-1:0]     a2_r,    a2_nxt;
  logic [milt_pkg::LEN_W-1:0]     len_r,   len_nxt;
  logic [milt_pkg::LEN_W-1:0]     idx_r,   idx_nxt;
  logic [milt_pkg::CYC_W-1:0]     cyc_r,   cyc_nxt;
  logic [milt_pkg::CYC_W-1:0]     cnt_r,   cnt_nxt;
  logic [milt_pkg::LEN_W-1:0]     dec_len;
  logic [milt_pkg::CYC_W-1:0]     dec_cyc;

  // Decoding straight off the read data saves a cycle per instruction
  milt_opcode_table u_table (
    .opcode (code_rdata),
    .len    (dec_len),
    .cyc    (dec_cyc)
  );

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    st_nxt    = st_r;
    pc_nxt    = pc_r;
    ipc_nxt   = ipc_r;
    addr_nxt  = addr_r;
    tgt_nxt   = tgt_r;
    rd_nxt    = 1'b0;
    pend_nxt  = pend_r;
    br_nxt    = br_r;
    start_nxt = 1'b0;
    done_nxt  = 1'b0;
    opc_nxt   = opc_r;
    a1_nxt    = a1_r;
    a2_nxt    = a2_r;
    len_nxt   = len_r;
    idx_nxt   = idx_r;
    cyc_nxt   = cyc_r;
    cnt_nxt   = cnt_r;
    case (st_r)
      milt_pkg::S_FETCH_OP: begin
        if (!pend_r) begin
          rd_nxt   = 1'b1;
          addr_nxt = pc_r;
          pend_nxt = 1'b1;
        end else if (code_rvalid) begin
          pend_nxt = 1'b0;
          opc_nxt  = code_rdata;
          len_nxt  = dec_len;
          cyc_nxt  = dec_cyc;
          ipc_nxt  = pc_r;
          idx_nxt  = milt_pkg::LEN_ONE;
          br_nxt   = 1'b0;
          if (dec_len == milt_pkg::LEN_ONE) begin
            st_nxt    = milt_pkg::S_EXEC;
            cnt_nxt   = dec_cyc - milt_pkg::CYC_ONE;
            start_nxt = 1'b1;
          end else begin
            st_nxt = milt_pkg::S_FETCH_ARG;
          end
        end
      end
      milt_pkg::S_FETCH_ARG: begin
        if (!pend_r) begin
          rd_nxt   = 1'b1;
          addr_nxt = ipc_r + {{(milt_pkg::PC_W-milt_pkg::LEN_W){1'b0}}, idx_r};
          pend_nxt = 1'b1;
        end else if (code_rvalid) begin
          pend_nxt = 1'b0;
          if (idx_r == milt_pkg::LEN_ONE) begin
            a1_nxt = code_rdata;
          end else begin
            a2_nxt = code_rdata;
          end
          // Execution waits for the last operand byte
          if (idx_r + milt_pkg::LEN_ONE == len_r) begin
            st_nxt    = milt_pkg::S_EXEC;
            cnt_nxt   = cyc_r - milt_pkg::CYC_ONE;
            start_nxt = 1'b1;
          end else begin
            idx_nxt = idx_r + milt_pkg::LEN_ONE;
          end
        end
      end
      milt_pkg::S_EXEC: begin
        if (branch_req) begin
          br_nxt  = 1'b1;
          tgt_nxt = branch_target;
        end
        if (cnt_r == '0) begin
          done_nxt = 1'b1;
          st_nxt   = milt_pkg::S_FETCH_OP;
          if (branch_req) begin
            pc_nxt = branch_target;
          end else if (br_r) begin
            pc_nxt = tgt_r;
          end else begin
            pc_nxt = ipc_r + {{(milt_pkg::PC_W-milt_pkg::LEN_W){1'b0}}, len_r};
          end
        end else begin
          cnt_nxt = cnt_r - milt_pkg::CYC_ONE;
        end
      end
      default: begin
        st_nxt   = milt_pkg::S_FETCH_OP;
        pend_nxt = 1'b0;
      end
    endcase
    exec_nxt = (st_nxt == milt_pkg::S_EXEC);
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r    <= milt_pkg::S_FETCH_OP;
      pc_r    <= milt_pkg::PC_RESET;
      ipc_r   <= milt_pkg::PC_RESET;
      addr_r  <= milt_pkg::PC_RESET;
      tgt_r   <= milt_pkg::PC_RESET;
      rd_r    <= 1'b0;
      pend_r  <= 1'b0;
      br_r    <= 1'b0;
      start_r <= 1'b0;
      done_r  <= 1'b0;
      exec_r  <= 1'b0;
      opc_r   <= milt_pkg::OPC_RESET;
      a1_r    <= milt_pkg::OPC_RESET;
      a2_r    <= milt_pkg::OPC_RESET;
      len_r   <= milt_pkg::LEN_ONE;
      idx_r   <= milt_pkg::LEN_ONE;
      cyc_r   <= milt_pkg::CYC_ONE;
      cnt_r   <= '0;
    end else begin
      st_r    <= st_nxt;
      pc_r    <= pc_nxt;
      ipc_r   <= ipc_nxt;
      addr_r  <= addr_nxt;
      tgt_r   <= tgt_nxt;
      rd_r    <= rd_nxt;
      pend_r  <= pend_nxt;
      br_r    <= br_nxt;
      start_r <= start_nxt;
      done_r  <= done_nxt;
      exec_r  <= exec_nxt;
      opc_r   <= opc_nxt;
      a1_r    <= a1_nxt;
      a2_r    <= a2_nxt;
      len_r   <= len_nxt;
      idx_r   <= idx_nxt;
      cyc_r   <= cyc_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  assign code_addr    = addr_r;
  assign code_rd      = rd_r;
  assign instr_opcode = opc_r;
  assign instr_arg1   = a1_r;
  assign instr_arg2   = a2_r;
  assign instr_start  = start_r;
  assign instr_done   = done_r;
  assign exec_active  = exec_r;
  assign prog_counter = pc_r;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  // Counters seen only by the checks: operand bytes taken and cycles executed
  logic [3:0] h_args_r;
  logic [3:0] h_exec_r;
  logic       h_brn_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      h_args_r <= 4'h0;
      h_exec_r <= 4'h0;
      h_brn_r  <= 1'b0;
    end else if (st_r == milt_pkg::S_FETCH_OP && pend_r && code_rvalid) begin
      h_args_r <= 4'h0;
      h_exec_r <= 4'h0;
      h_brn_r  <= 1'b0;
    end else begin
      if (st_r == milt_pkg::S_FETCH_ARG && pend_r && code_rvalid) begin
        h_args_r <= h_args_r + 4'h1;
      end
      if (st_r == milt_pkg::S_EXEC) begin
        h_exec_r <= h_exec_r + 4'h1;
        h_brn_r  <= h_brn_r | branch_req;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_retire(hit);
    done_r && hit;
  endsequence

  property p_shape(hit, int l, int c);
    s_retire(hit) |-> (h_args_r == l - 1) && (h_exec_r == c);
  endproperty

  AST_ADD_REG: assert property (p_shape(opc_r inside {[8'h28:8'h2f], [8'h38:8'h3f],
    8'h26, 8'h27, 8'h36, 8'h37}, 1, 1)) else $error("add short form shape");
  AST_ADD_DIR: assert property (p_shape(opc_r inside {8'h24, 8'h25, 8'h34, 8'h35}, 2, 1))
    else $error("add long form shape");
  AST_SUB_REG: assert property (p_shape(opc_r inside {[8'h98:8'h9f], 8'h96, 8'h97}, 1, 1))
    else $error("subtract short form shape");
  AST_SUB_DIR: assert property (p_shape(opc_r inside {8'h94, 8'h95}, 2, 1))
    else $error("subtract long form shape");
  AST_AND_IMM_DIR: assert property (p_shape(opc_r == 8'h53, 3, 2))
    else $error("and immediate to direct shape");
  AST_AND_DIR_ACC: assert property (p_shape(opc_r == 8'h55, 2, 2))
    else $error("and direct to acc shape");
  AST_OR_ACC_DIR: assert property (p_shape(opc_r == 8'h42, 2, 2))
    else $error("or acc to direct shape");
  AST_OR_IMM_DIR: assert property (p_shape(opc_r == 8'h43, 3, 2))
    else $error("or immediate to direct shape");
  AST_XOR_IMM: assert property (p_shape(opc_r == 8'h64, 2, 1))
    else $error("xor immediate shape");
  AST_XOR_REG: assert property (p_shape(opc_r inside {[8'h68:8'h6f]}, 1, 1))
    else $error("xor register shape");
  AST_ROTATE: assert property (p_shape(opc_r inside {8'h03, 8'h13, 8'h23, 8'h33}, 1, 1))
    else $error("rotate shape");
  AST_SWAP: assert property (p_shape(opc_r == 8'hc4, 1, 1))
    else $error("nibble swap shape");
  AST_LOAD_IMM: assert property (p_shape(opc_r == 8'h74, 2, 3))
    else $error("load immediate shape");
  AST_ACC_TO_REG: assert property (p_shape(opc_r inside {[8'hf8:8'hff]}, 1, 3))
    else $error("acc to working register shape");
  AST_DIR_DIR: assert property (p_shape(opc_r == 8'h85, 3, 3))
    else $error("direct to direct shape");
  AST_DATA_POINTER_LOAD: assert property (p_shape(opc_r == 8'h90, 3, 3))
    else $error("data pointer load shape");
  AST_CODE_RD_DP: assert property (p_shape(opc_r == 8'h93, 1, 2))
    else $error("code read via pointer shape");
  AST_CODE_RD_PC: assert property (p_shape(opc_r == 8'h83, 1, 1))
    else $error("code read via pc shape");
  AST_XRAM_WR8: assert property (p_shape(opc_r inside {8'hf2, 8'hf3}, 1, 2))
    else $error("external 8-bit write shape");
  AST_XRAM_OTHER: assert property (p_shape(opc_r inside {8'he0, 8'he2, 8'he3, 8'hf0}, 1, 1))
    else $error("external access shape");
  AST_PUSH_POP: assert property (p_shape(opc_r inside {8'hc0, 8'hd0}, 2, 2))
    else $error("push pop shape");
  AST_LOW_DIGIT: assert property (p_shape(opc_r inside {8'hd6, 8'hd7}, 1, 2))
    else $error("low digit exchange shape");
  AST_OR_NOT_BIT: assert property (p_shape(opc_r == 8'ha0, 2, 1))
    else $error("or complement bit shape");
  AST_AND_NOT_BIT: assert property (p_shape(opc_r == 8'hb0, 2, 2))
    else $error("and complement bit shape");
  AST_CARRY_TO_BIT: assert property (p_shape(opc_r == 8'h92, 2, 1))
    else $error("carry to bit shape");
  AST_BIT_JUMP_CLR: assert property (p_shape(opc_r == 8'h10, 3, 3))
    else $error("bit jump and clear shape");
  AST_CMP_JUMP: assert property (p_shape(opc_r inside {[8'hb4:8'hbf]}, 3, 3))
    else $error("compare jump shape");
  AST_DEC_JUMP_DIR: assert property (p_shape(opc_r == 8'hd5, 3, 2))
    else $error("decrement jump direct shape");
  AST_DEC_JUMP_REG: assert property (p_shape(opc_r inside {[8'hd8:8'hdf]}, 2, 2))
    else $error("decrement jump register shape");
  AST_IND_JUMP: assert property (p_shape(opc_r == 8'h73, 1, 2))
    else $error("indirect jump shape");
  AST_REL_JUMP: assert property (p_shape(opc_r inside {8'h80, 8'h60, 8'h70}, 2, 2))
    else $error("relative jump shape");

  sequence s_seq_retire;
    done_r && !h_brn_r;
  endsequence

  AST_PC_ADVANCE: assert property (s_seq_retire |->
    pc_r == ipc_r + {{(milt_pkg::PC_W-milt_pkg::LEN_W){1'b0}}, len_r})
    else $error("pc did not advance by length");
  AST_ARGS_FIRST: assert property (start_r |-> h_args_r == {2'b00, len_r} - 4'h1)
    else $error("execution began before all operands");
  AST_NEXT_FETCH: assert property (done_r |-> ##1 rd_r && addr_r == pc_r)
    else $error("next opcode not fetched at pc");
endmodule // milt_sequencer

// ---- milt_code_mem_model.sv ----
// Behavioural program code memory answering the sequencer's byte reads
`timescale 1ns/1ps
module milt_code_mem_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        code_rd,
  input  wire logic [15:0] code_addr,
  input  wire logic [2:0]  delay,
  output logic             code_rvalid,
  output logic      [7:0]  code_rdata
);
  // ---------------------------------------------------------------------------
  // Storage and reply timing
  // ---------------------------------------------------------------------------
  logic [7:0] mem [0:1023];
  logic       pend_r;
  logic [2:0] wait_r;
  logic [9:0] addr_r;

  // Idle data toggles so a stale byte is never mistaken for a reply
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pend_r      <= 1'b0;
      wait_r      <= 3'h0;
      addr_r      <= 10'h000;
      code_rvalid <= 1'b0;
      code_rdata  <= 8'h00;
    end else begin
      code_rvalid <= 1'b0;
      code_rdata  <= ~code_rdata;
      if (code_rd && delay == 3'h0) begin
        code_rvalid <= 1'b1;
        code_rdata  <= mem[code_addr[9:0]];
      end else if (code_rd) begin
        pend_r <= 1'b1;
        addr_r <= code_addr[9:0];
        wait_r <= delay - 3'h1;
      end else if (pend_r && wait_r != 3'h0) begin
        wait_r <= wait_r - 3'h1;
      end else if (pend_r) begin
        pend_r      <= 1'b0;
        code_rvalid <= 1'b1;
        code_rdata  <= mem[addr_r];
      end
    end
  end
endmodule // milt_code_mem_model

// ---- test_mcu_instruction_length_timing.sv ----
// Self-checking bench for the fetch and timing sequencer
`timescale 1ns/1ps
module test_mcu_instruction_length_timing;
  // ---------------------------------------------------------------------------
  // Opcode table: {base, span, bytes, cycles}
  // ---------------------------------------------------------------------------
  localparam int NOPS = 60;
  localparam logic [23:0] OPS [0:NOPS-1] = '{
    24'h2808_11, 24'h2501_21, 24'h2602_11, 24'h2401_21,
    24'h3808_11, 24'h3501_21, 24'h3602_11, 24'h3401_21,
    24'h9808_11, 24'h9501_21, 24'h9602_11, 24'h9401_21,
    24'h5301_32, 24'h5501_22, 24'h4201_22, 24'h4301_32,
    24'h6401_21, 24'h6808_11, 24'h2301_11, 24'h3301_11,
    24'h0301_11, 24'h1301_11, 24'hc401_11, 24'h7401_23,
    24'hf808_13, 24'h8501_33, 24'h9001_33, 24'h9301_12,
    24'h8301_11, 24'he202_11, 24'he001_11, 24'hf202_12,
    24'hf001_11, 24'hc001_22, 24'hd001_22, 24'hd602_12,
    24'ha001_21, 24'hb001_22, 24'h9201_21, 24'h1001_33,
    24'hb501_33, 24'hb401_33, 24'hb602_33, 24'hb808_33,
    24'hd501_32, 24'hd808_22, 24'h7301_12, 24'h8001_22,
    24'h6001_22, 24'h7001_22, 24'h0001_11, 24'h0501_22,
    24'h8401_1a, 24'ha301_13, 24'h2001_32, 24'h0201_33,
    24'h0101_23, 24'hc808_12, 24'h7808_22, 24'he401_11};
  logic        core_clk, rst, code_rvalid, branch_req, code_rd, slow;
  logic        instr_start, instr_done, exec_active;
  logic [7:0]  code_rdata, instr_opcode, instr_arg1, instr_arg2, prog [0:1023];
  logic [15:0] branch_target, code_addr, prog_counter, seed, pc, tgt;
  logic [2:0]  mem_delay;
  logic [7:0]  nrd, ncyc, len;
  logic        took;
  int          failures, num_checks, ninstr;
  logic [15:0] starts [$];

  milt_sequencer dut (.core_clk(core_clk), .rst(rst), .code_rdata(code_rdata),
    .code_rvalid(code_rvalid), .branch_req(branch_req), .branch_target(branch_target),
    .code_addr(code_addr), .code_rd(code_rd), .instr_opcode(instr_opcode),
    .instr_arg1(instr_arg1), .instr_arg2(instr_arg2), .instr_start(instr_start),
    .instr_done(instr_done), .exec_active(exec_active), .prog_counter(prog_counter));
  milt_code_mem_model mem_model (.core_clk(core_clk), .rst(rst), .code_rd(code_rd),
    .code_addr(code_addr), .delay(mem_delay), .code_rvalid(code_rvalid),
    .code_rdata(code_rdata));

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  // Bytes or cycles of an opcode, from the table above
  function automatic logic [7:0] look(input logic [7:0] opc, input bit want_cyc);
    for (int i = 0; i < NOPS; i++)
      if ({1'b0, opc} >= {1'b0, OPS[i][23:16]} &&
          {1'b0, opc} < {1'b0, OPS[i][23:16]} + {1'b0, OPS[i][15:8]})
        return want_cyc ? {4'h0, OPS[i][3:0]} : {4'h0, OPS[i][7:4]};
    return 8'h01;
  endfunction
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d instructions %0d", num_checks, failures, ninstr);
    if (failures == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Clock, stimulus and sequence
  // ---------------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // A branch, once raised in execute, is held so no sample ever withdraws it
  always @(posedge core_clk) begin
    logic [15:0] r;
    r = rnd();
    mem_delay <= r[2:0] & {3{slow}};
    if (instr_done)
      branch_req <= 1'b0;
    else if (exec_active && r[7:5] == 3'h0) begin
      branch_req    <= 1'b1;
      branch_target <= starts[r % starts.size()];
    end else if (!exec_active)
      branch_req <= r[8] & r[9];
  end

  initial begin
    logic [23:0] e;
    logic [15:0] a, r;
    seed = 16'd8784;
    rst = 1'b1;
    slow = 1'b0;
    branch_req = 1'b0;
    branch_target = 16'h0000;
    mem_delay = 3'h0;
    failures = 0;
    num_checks = 0;
    ninstr = 0;
    for (int i = 0; i < 1024; i++) prog[i] = 8'h00;
    a = 16'h0000;
    // Every table entry once in order, then random picks
    for (int k = 0; a < 16'd1000; k++) begin
      r = rnd();
      e = (k < NOPS) ? OPS[k] : OPS[r % NOPS];
      starts.push_back(a);
      r = rnd();
      prog[a[9:0]] = e[23:16] + (r[7:0] % e[15:8]);
      for (int j = 1; j < e[7:4]; j++) begin
        r = rnd();
        prog[a[9:0] + j] = r[7:0];
      end
      a = a + {12'h000, e[7:4]};
    end
    for (int i = 0; i < 1024; i++) mem_model.mem[i] = prog[i];
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    repeat (5000) @(posedge core_clk);
    rst  <= 1'b1;
    slow <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    repeat (6000) @(posedge core_clk);
    chk_byte(8'(ninstr > 500), 8'h01);
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    end_of_test();
  end

  // ---------------------------------------------------------------------------
  // Monitor: reads, execute length and next pc
  // ---------------------------------------------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pc = 16'h0000;
      nrd = 8'h00;
      ncyc = 8'h00;
      took = 1'b0;
    end else begin
      if (code_rd) begin
        chk_word(code_addr, pc + {8'h00, nrd});
        nrd = nrd + 8'h01;
      end
      if (exec_active) begin
        ncyc = ncyc + 8'h01;
        if (branch_req) begin
          took = 1'b1;
          tgt = branch_target;
        end
      end
      len = look(prog[pc[9:0]], 1'b0);
      if (instr_start) begin
        chk_byte(instr_opcode, prog[pc[9:0]]);
        chk_byte(nrd, len);
        if (len > 8'h01) chk_byte(instr_arg1, prog[pc[9:0] + 10'h001]);
        if (len > 8'h02) chk_byte(instr_arg2, prog[pc[9:0] + 10'h002]);
      end
      if (instr_done) begin
        chk_byte(ncyc, look(prog[pc[9:0]], 1'b1));
        pc = took ? tgt : pc + {8'h00, len};
        chk_word(prog_counter, pc);
        nrd = 8'h00;
        ncyc = 8'h00;
        took = 1'b0;
        ninstr++;
      end
    end
  end
endmodule // test_mcu_instruction_length_timing
